// file: inc/sld_consts.vh
// Constants for the serial LED sink driver control block
`ifndef SLD_CONSTS_VH
`define SLD_CONSTS_VH

`define SLD_CHAN_W       8
`define SLD_FIFO_DEPTH   16
`define SLD_FIFO_AW      4
`define SLD_SYNC_W       12
`define SLD_SHREG_RST    8'h00
`define SLD_OUT_LATCH_RST 8'h00
`define SLD_GAIN_RST     8'hff
`define SLD_ERR_RST      8'h00
`define SLD_BITCNT_W     4
`define SLD_BITCNT_FULL  4'h8
`define SLD_SWITCH_PAT   3'h5

`endif

// file: rtl/sld_sync.v
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module sld_sync #(
    parameter W = 1
) (
    input  wire         i_mclk,
    input  wire         i_srst,
    input  wire [W-1:0] i_async,
    output wire [W-1:0] o_sync
);
    reg [W-1:0] meta_r;
    reg [W-1:0] sync_r;

    always @(posedge i_mclk) begin
        if (i_srst) begin
            meta_r <= {W{1'b0}};
            sync_r <= {W{1'b0}};
        end else begin
            meta_r <= i_async;
            sync_r <= meta_r;
        end
    end

    assign o_sync = sync_r;
endmodule
`default_nettype wire

// file: rtl/sld_fifo.v
// Synchronous FIFO with valid/ready on both sides and a flush
`timescale 1ns/1ps
`default_nettype none
module sld_fifo #(
    parameter W     = 8,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire         i_mclk,
    input  wire         i_srst,
    input  wire         i_flush,
    input  wire [W-1:0] i_in_data,
    input  wire         i_in_valid,
    output wire         o_in_ready,
    output wire [W-1:0] o_out_data,
    output wire         o_out_valid,
    input  wire         i_out_ready
);
    // DEPTH must equal 2**AW; the extra pointer bit tells full from empty
    reg [W-1:0] mem [0:DEPTH-1];
    reg [AW:0]  wr_r;
    reg [AW:0]  rd_r;
    wire        full;
    wire        empty;
    wire        push;
    wire        pop;

    assign full        = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);
    assign empty       = (wr_r == rd_r);
    assign o_in_ready  = ~full;
    assign o_out_valid = ~empty;
    assign push        = i_in_valid & ~full;
    assign pop         = i_out_ready & ~empty;
    assign o_out_data  = mem[rd_r[AW-1:0]];

    always @(posedge i_mclk) begin
        if (push) begin
            mem[wr_r[AW-1:0]] <= i_in_data;
        end
    end

    always @(posedge i_mclk) begin
        if (i_srst || i_flush) begin
            wr_r <= {(AW+1){1'b0}};
            rd_r <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_r <= wr_r + {{AW{1'b0}}, 1'b1};
            end
            if (pop) begin
                rd_r <= rd_r + {{AW{1'b0}}, 1'b1};
            end
        end
    end
endmodule
`default_nettype wire

// file: rtl/sld_top.v
// Control logic of an eight-channel serial LED sink driver
`timescale 1ns/1ps
`default_nettype none
`include "sld_consts.vh"
module sld_top #(
    parameter CHAN_W     = `SLD_CHAN_W,
    parameter FIFO_DEPTH = `SLD_FIFO_DEPTH,
    parameter FIFO_AW    = `SLD_FIFO_AW
) (
    input  wire              i_mclk,
    input  wire              i_srst,
    input  wire              i_serial_clk,
    input  wire              i_serial_in,
    input  wire              i_latch_strobe,
    input  wire              i_latch_strobe_driven,
    input  wire              i_drive_enable_n,
    input  wire              i_drive_enable_n_driven,
    input  wire [CHAN_W-1:0] i_chan_fault,
    output wire              o_serial_out,
    output wire [CHAN_W-1:0] o_sink_channels,
    output wire [CHAN_W-1:0] o_gain_code,
    output wire              o_special_mode,
    output wire              o_mode_switching,
    output wire              o_detect_active,
    output wire              o_err_push_stall
);
    localparam [2:0] ST_NORMAL  = 3'b001;
    localparam [2:0] ST_SWITCH  = 3'b010;
    localparam [2:0] ST_SPECIAL = 3'b100;
    localparam       SYNC_W     = CHAN_W + 4;

    // Pin resolution: an undriven strobe reads low, an undriven enable reads high
    wire le_pin;
    wire oe_n_pin;
    assign le_pin   = i_latch_strobe & i_latch_strobe_driven;
    assign oe_n_pin = i_drive_enable_n | ~i_drive_enable_n_driven;

    // All pins cross into the i_mclk domain together so they stay aligned
    wire [SYNC_W-1:0]      sync_out;
    wire [CHAN_W-1:0]      s_fault;
    wire                   s_sclk;
    wire                   s_sin;
    wire                   s_le;
    wire                   s_oe_n;

    // Enable crosses inverted so a cleared synchroniser reads as blanked: no false rise after reset
    sld_sync #(
        .W (SYNC_W)
    ) u_sync (
        .i_mclk  (i_mclk),
        .i_srst  (i_srst),
        .i_async ({i_chan_fault, i_serial_clk, i_serial_in, le_pin, ~oe_n_pin}),
        .o_sync  (sync_out)
    );

    assign s_fault = sync_out[SYNC_W-1:4];
    assign s_sclk  = sync_out[3];
    assign s_sin   = sync_out[2];
    assign s_le    = sync_out[1];
    assign s_oe_n  = ~sync_out[0];

    // State
    reg [2:0]              state_r;
    reg [2:0]              state_nxt;
    reg                    sclk_d_r;
    reg                    oe_n_d_r;
    reg [1:0]              oe_hist_r;
    reg [CHAN_W-1:0]       shreg_r;
    reg [CHAN_W-1:0]       out_latch_r;
    reg [CHAN_W-1:0]       gain_r;
    reg [CHAN_W-1:0]       err_r;
    reg [CHAN_W-1:0]       sink_r;
    reg [`SLD_BITCNT_W-1:0] bitcnt_r;
    reg                    push_pend_r;

    wire sclk_rise;
    wire oe_n_rise;
    wire switch_req;
    wire in_normal;
    wire in_special;
    wire enter_normal;
    wire detect_on;
    wire readout_done;

    // Error snapshot FIFO signals
    wire              fifo_in_ready;
    wire [CHAN_W-1:0] fifo_out_data;
    wire              fifo_out_valid;
    wire              fifo_pop;

    assign sclk_rise  = s_sclk & ~sclk_d_r;
    assign oe_n_rise  = s_oe_n & ~oe_n_d_r;
    assign in_normal  = (state_r == ST_NORMAL);
    assign in_special = (state_r == ST_SPECIAL);

    // Enable was high, low for exactly one clock period, then high again
    assign switch_req = sclk_rise && ({oe_hist_r, s_oe_n} == `SLD_SWITCH_PAT);

    assign enter_normal = (state_r != ST_NORMAL) && (state_nxt == ST_NORMAL);
    assign detect_on    = in_special & ~s_oe_n;

    // A new snapshot is loaded only after the previous one was fully shifted out
    assign readout_done = (bitcnt_r == `SLD_BITCNT_FULL);
    assign fifo_pop     = in_special & fifo_out_valid & readout_done & ~sclk_rise;

    // Mode sequencing
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_NORMAL: begin
                if (switch_req) begin
                    state_nxt = ST_SWITCH;
                end
            end
            ST_SWITCH: begin
                if (sclk_rise) begin
                    state_nxt = s_le ? ST_SPECIAL : ST_NORMAL;
                end
            end
            ST_SPECIAL: begin
                if (switch_req) begin
                    state_nxt = ST_SWITCH;
                end
            end
            default: begin
                state_nxt = ST_NORMAL;
            end
        endcase
    end

    always @(posedge i_mclk) begin
        if (i_srst) begin
            state_r   <= ST_NORMAL;
            sclk_d_r  <= 1'b0;
            oe_n_d_r  <= 1'b1;
            oe_hist_r <= 2'b11;
        end else begin
            state_r  <= state_nxt;
            sclk_d_r <= s_sclk;
            oe_n_d_r <= s_oe_n;
            if (sclk_rise) begin
                oe_hist_r <= {oe_hist_r[0], s_oe_n};
            end
        end
    end

    // Shift register: shifts in every mode, loads error snapshots in special mode
    always @(posedge i_mclk) begin
        if (i_srst) begin
            shreg_r  <= `SLD_SHREG_RST;
            bitcnt_r <= `SLD_BITCNT_FULL;
        end else if (fifo_pop) begin
            shreg_r  <= fifo_out_data;
            bitcnt_r <= {`SLD_BITCNT_W{1'b0}};
        end else if (sclk_rise) begin
            shreg_r <= {shreg_r[CHAN_W-2:0], s_sin};
            // Leaving the switch phase always lands on a clock rise; drop any half-read count
            if (enter_normal) begin
                bitcnt_r <= `SLD_BITCNT_FULL;
            end else if (!readout_done) begin
                bitcnt_r <= bitcnt_r + {{(`SLD_BITCNT_W-1){1'b0}}, 1'b1};
            end
        end else if (enter_normal) begin
            bitcnt_r <= `SLD_BITCNT_FULL;
        end
    end

    // Last stage drives the cascade or the readback path
    assign o_serial_out = shreg_r[CHAN_W-1];

    // The output latch in normal mode and the gain latch in special mode are transparent while the strobe is high; both hold when it drops.
    // They follow the registered shift contents, so they lag a shift by one i_mclk.
    always @(posedge i_mclk) begin
        if (i_srst) begin
            out_latch_r <= `SLD_OUT_LATCH_RST;
            gain_r      <= `SLD_GAIN_RST;
        end else if (s_le) begin
            if (in_normal) begin
                out_latch_r <= shreg_r;
            end else if (in_special) begin
                gain_r <= shreg_r;
            end
        end
    end

    // Gain code drives the analog regulator: 256 steps from 1/12 to 127/128
    assign o_gain_code = gain_r;

    // Sticky per-channel error register, cleared when normal mode resumes
    always @(posedge i_mclk) begin
        if (i_srst) begin
            err_r <= `SLD_ERR_RST;
        end else if (enter_normal) begin
            err_r <= `SLD_ERR_RST;
        end else if (detect_on) begin
            err_r <= err_r | s_fault;
        end
    end

    // End of a detection window queues a snapshot; a full FIFO holds it back
    always @(posedge i_mclk) begin
        if (i_srst) begin
            push_pend_r <= 1'b0;
        end else if (enter_normal) begin
            push_pend_r <= 1'b0;
        end else if (in_special && oe_n_rise) begin
            push_pend_r <= 1'b1;
        end else if (fifo_in_ready) begin
            push_pend_r <= 1'b0;
        end
    end

    sld_fifo #(
        .W     (CHAN_W),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_err_fifo (
        .i_mclk      (i_mclk),
        .i_srst      (i_srst),
        .i_flush     (enter_normal),
        .i_in_data   (err_r),
        .i_in_valid  (push_pend_r),
        .o_in_ready  (fifo_in_ready),
        .o_out_data  (fifo_out_data),
        .o_out_valid (fifo_out_valid),
        .i_out_ready (fifo_pop)
    );

    // Channel drive: blanked while the enable is high in every mode
    always @(posedge i_mclk) begin
        if (i_srst) begin
            sink_r <= {CHAN_W{1'b0}};
        end else if (s_oe_n) begin
            sink_r <= {CHAN_W{1'b0}};
        end else begin
            sink_r <= out_latch_r;
        end
    end

    assign o_sink_channels  = sink_r;
    assign o_special_mode   = in_special;
    assign o_mode_switching = (state_r == ST_SWITCH);
    assign o_detect_active  = detect_on;
    assign o_err_push_stall = push_pend_r & ~fifo_in_ready;
endmodule
`default_nettype wire

// file: verification/sld_top_asserts.sv
// Port-level concurrent checks for the sink driver control block
`timescale 1ns/1ps
`default_nettype none
module sld_top_asserts (
    input wire logic       i_mclk,
    input wire logic       i_srst,
    input wire logic       i_serial_clk,
    input wire logic       i_latch_strobe,
    input wire logic       i_latch_strobe_driven,
    input wire logic       i_drive_enable_n,
    input wire logic       i_drive_enable_n_driven,
    input wire logic       o_serial_out,
    input wire logic [7:0] o_sink_channels,
    input wire logic [7:0] o_gain_code,
    input wire logic       o_special_mode,
    input wire logic       o_mode_switching,
    input wire logic       o_detect_active
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_srst);
    wire en_low = !i_drive_enable_n && i_drive_enable_n_driven;
    wire stb_on = i_latch_strobe && i_latch_strobe_driven;
    // Four cycles cover both sampling stages and the output register
    sequence s_blank;
        (i_drive_enable_n && i_drive_enable_n_driven) [*4];
    endsequence
    sequence s_hold;
        (!o_special_mode && !stb_on && en_low) [*6];
    endsequence
    // Reset guard keeps a reset in mid-switch from looking like an exit
    sequence s_sw_done;
        $past(o_mode_switching && !i_srst) && !o_mode_switching;
    endsequence
    property p_blank;
        s_blank |-> o_sink_channels == 8'h00;
    endproperty
    a_blank: assert property (p_blank) else $error("channels on while blanked");
    property p_pullup;
        (!i_drive_enable_n_driven) [*4] |-> o_sink_channels == 8'h00;
    endproperty
    a_pullup: assert property (p_pullup) else $error("undriven enable not blanking");
    property p_hold;
        s_hold |-> $stable(o_sink_channels);
    endproperty
    a_hold: assert property (p_hold) else $error("output latch moved");
    property p_gain;
        (!o_special_mode) [*3] |-> $stable(o_gain_code);
    endproperty
    a_gain: assert property (p_gain) else $error("gain moved outside special");
    property p_serial;
        (!o_special_mode && !i_serial_clk) [*5] |-> $stable(o_serial_out);
    endproperty
    a_serial: assert property (p_serial) else $error("serial out moved without clock");
    property p_detect;
        o_detect_active |-> o_special_mode && ($past(en_low, 2) || $past(en_low, 3));
    endproperty
    a_detect: assert property (p_detect) else $error("detect without cause");
    property p_excl;
        !(o_special_mode && o_mode_switching);
    endproperty
    a_excl: assert property (p_excl) else $error("two phases at once");
    property p_to_spec;
        s_sw_done ##0 o_special_mode |-> $past(stb_on, 3);
    endproperty
    a_to_spec: assert property (p_to_spec) else $error("special without strobe high");
    property p_to_norm;
        s_sw_done ##0 !o_special_mode |-> !$past(stb_on, 3);
    endproperty
    a_to_norm: assert property (p_to_norm) else $error("normal with strobe high");
endmodule
bind sld_top sld_top_asserts sld_top_asserts_inst (.*);
`default_nettype wire

// file: verification/sld_ctl_model.sv
// Behavioural system controller on the serial pins
`timescale 1ns/1ps
`default_nettype none
module sld_ctl_model (
    input  wire logic i_mclk,
    output var  logic o_serial_clk,
    output var  logic o_serial_in,
    output var  logic o_latch_strobe,
    output var  logic o_drive_enable_n
);
    initial begin
        o_serial_clk = 1'b0;
        o_serial_in = 1'b0;
        o_latch_strobe = 1'b0;
        o_drive_enable_n = 1'b1;
    end
    // Ends just past the edge so callers see settled outputs
    task automatic tick(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask
    // Clock stands still between pulses; levels outlast the sampling floor
    task automatic clk_pulse(input logic d);
        @(posedge i_mclk) o_serial_in <= d;
        tick(2);
        @(posedge i_mclk) o_serial_clk <= 1'b1;
        tick(3);
        @(posedge i_mclk) o_serial_clk <= 1'b0;
        tick(3);
    endtask
    task automatic shift_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) clk_pulse(b[i]);
    endtask
    task automatic strobe_pulse();
        @(posedge i_mclk) o_latch_strobe <= 1'b1;
        tick(3);
        @(posedge i_mclk) o_latch_strobe <= 1'b0;
        tick(4);
    endtask
    task automatic set_en(input logic v);
        @(posedge i_mclk) o_drive_enable_n <= v;
        tick(6);
    endtask
    // Enable low across exactly one clock rise, then the strobe level picks the mode
    task automatic mode_req(input logic special);
        clk_pulse(1'b0);
        set_en(1'b0);
        clk_pulse(1'b0);
        set_en(1'b1);
        clk_pulse(1'b0);
        @(posedge i_mclk) o_latch_strobe <= special;
        clk_pulse(1'b0);
        @(posedge i_mclk) o_latch_strobe <= 1'b0;
        tick(4);
    endtask
endmodule
`default_nettype wire

// file: verification/sld_top_test.sv
// Self-checking bench for the sink driver control block
`timescale 1ns/1ps
`default_nettype none
`include "sld_consts.vh"
module sld_top_test;
    logic       i_mclk = 1'b0;
    logic       i_srst;
    logic       stb_drv;
    logic       en_drv;
    logic [7:0] fault;
    wire        sclk;
    wire        sin;
    wire        stb;
    wire        en_n;
    wire        o_serial_out;
    wire [7:0]  o_sink_channels;
    wire [7:0]  o_gain_code;
    wire        o_special_mode;
    wire        o_mode_switching;
    wire        o_detect_active;
    wire        o_err_push_stall;
    int         fail_count = 0;
    int         n_tests = 0;
    always #25 i_mclk = ~i_mclk;
    sld_ctl_model sld_ctl_model_inst (.i_mclk(i_mclk), .o_serial_clk(sclk), .o_serial_in(sin),
        .o_latch_strobe(stb), .o_drive_enable_n(en_n));
    sld_top sld_top_inst (.i_mclk(i_mclk), .i_srst(i_srst), .i_serial_clk(sclk), .i_serial_in(sin),
        .i_latch_strobe(stb), .i_latch_strobe_driven(stb_drv), .i_drive_enable_n(en_n),
        .i_drive_enable_n_driven(en_drv), .i_chan_fault(fault), .o_serial_out(o_serial_out),
        .o_sink_channels(o_sink_channels), .o_gain_code(o_gain_code), .o_special_mode(o_special_mode),
        .o_mode_switching(o_mode_switching), .o_detect_active(o_detect_active),
        .o_err_push_stall(o_err_push_stall));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks=%0d mismatches=%0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic en(input logic v);
        sld_ctl_model_inst.set_en(v);
    endtask
    task automatic read_byte(output logic [7:0] v);
        for (int i = 7; i >= 0; i--) begin
            v[i] = o_serial_out;
            sld_ctl_model_inst.clk_pulse(1'b0);
        end
    endtask
    task automatic t_reset();
        i_srst  <= 1'b1;
        stb_drv <= 1'b1;
        en_drv  <= 1'b1;
        fault   <= 8'h00;
        repeat (20) @(posedge i_mclk);
        i_srst <= 1'b0;
        sld_ctl_model_inst.tick(3);
        chk(o_gain_code, `SLD_GAIN_RST);
        chk({o_sink_channels[3:0], o_serial_out, o_special_mode, o_mode_switching, o_err_push_stall}, 8'h00);
    endtask
    task automatic t_normal();
        logic [7:0] ob;
        logic [7:0] nb;
        ob = 8'ha5;
        nb = 8'h3c;
        sld_ctl_model_inst.shift_byte(ob);
        sld_ctl_model_inst.strobe_pulse();
        for (int i = 7; i >= 0; i--) begin
            chk(o_serial_out, ob[i]);
            sld_ctl_model_inst.clk_pulse(nb[i]);
        end
        en(1'b0);
        chk(o_sink_channels, ob);
        en(1'b1);
        chk(o_sink_channels, 8'h00);
        @(posedge i_mclk) en_drv <= 1'b0;
        en(1'b0);
        chk(o_sink_channels, 8'h00);
        en(1'b1);
        @(posedge i_mclk) en_drv <= 1'b1;
        @(posedge i_mclk) stb_drv <= 1'b0;
        sld_ctl_model_inst.strobe_pulse();
        @(posedge i_mclk) stb_drv <= 1'b1;
        en(1'b0);
        chk(o_sink_channels, ob);
        sld_ctl_model_inst.strobe_pulse();
        chk(o_sink_channels, nb);
        en(1'b1);
    endtask
    task automatic t_special();
        sld_ctl_model_inst.mode_req(1'b1);
        chk(o_special_mode, 8'h01);
        sld_ctl_model_inst.shift_byte(8'h5a);
        sld_ctl_model_inst.strobe_pulse();
        chk(o_gain_code, 8'h5a);
    endtask
    // Fault bits stay sticky, so every queued snapshot reads the same
    task automatic t_err();
        logic [7:0] v;
        @(posedge i_mclk) fault <= 8'h81;
        en(1'b0);
        chk(o_detect_active, 8'h01);
        en(1'b1);
        @(posedge i_mclk) fault <= 8'h00;
        read_byte(v);
        chk(v, 8'h81);
        repeat (20) begin
            en(1'b0);
            en(1'b1);
        end
        chk(o_err_push_stall, 8'h01);
        repeat (18) begin
            read_byte(v);
            chk(v, 8'h81);
        end
        chk(o_err_push_stall, 8'h00);
    endtask
    task automatic t_return();
        logic [7:0] v;
        sld_ctl_model_inst.mode_req(1'b0);
        chk(o_special_mode, 8'h00);
        en(1'b0);
        chk(o_sink_channels, 8'h3c);
        en(1'b1);
        sld_ctl_model_inst.shift_byte(8'hff);
        sld_ctl_model_inst.mode_req(1'b1);
        en(1'b0);
        en(1'b1);
        read_byte(v);
        chk(v, 8'h00);
        @(posedge i_mclk) fault <= 8'h7e;
        en(1'b0);
        chk(o_detect_active, 8'h01);
        en(1'b1);
        @(posedge i_mclk) fault <= 8'h00;
        read_byte(v);
        chk(v, 8'h7e);
    endtask
    initial begin
        t_reset();
        t_normal();
        t_special();
        t_err();
        t_return();
        end_sim();
    end
    // Tests take about 2800 cycles; allow about seven times that
    initial begin
        #1000000;
        fail_count++;
        end_sim();
    end
endmodule
`default_nettype wire
